// ### hw/pmdtc_pkg.sv
// Package of constants and types for the power-mode direct transfer controller
package pmdtc_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_SYSCTL1 = 8'h00;
  localparam logic [7:0] ADDR_SYSCTL2 = 8'h04;
  localparam logic [7:0] ADDR_TMRMODE = 8'h08;
  localparam logic [7:0] ADDR_IRQEN2 = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // ==========================================================
  // Field positions
  localparam int SC1_STANDBY_SELECT_BIT = 0;
  localparam int SC1_LSPD_BIT = 1;
  localparam int SC1_WAIT_LSB = 2;
  localparam int SC2_MSPD_BIT = 0;
  localparam int SC2_DTEN_BIT = 1;
  localparam int SC2_SADIV_LO_BIT = 2;
  localparam int SC2_SADIV_HI_BIT = 3;
  localparam int TMR_MODE_BIT = 0;
  localparam int IEN_DT_BIT = 0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_CPURST_BIT = 4;
  // ==========================================================
  // Timing, in states of the relevant CPU clock
  localparam int PRE_STATES = 3;
  localparam int EXC_STATES = 14;
  localparam int SETTLE_BASE_STATES = 8192;
  localparam int WAIT_CODE_MAX = 4;
  localparam int CNT_W = 18;
  // Source clock cycles per CPU state (watch clock in subactive); medium speed is one eighth of high speed
  localparam logic [4:0] DIV_HIGH = 5'h02;
  localparam logic [4:0] DIV_MED = 5'h10;
  localparam logic [4:0] DIV_SUB2 = 5'h02;
  localparam logic [4:0] DIV_SUB4 = 5'h04;
  localparam logic [4:0] DIV_SUB8 = 5'h08;
  // ==========================================================
  // Modes and controller states
  typedef enum logic [2:0] {
    MD_HIGH, MD_MED, MD_SUB, MD_SLEEP, MD_STANDBY, MD_WATCH, MD_SUBSLEEP
  } pmdtc_mode_e;
  typedef enum logic [2:0] {
    ST_RUN, ST_PRE, ST_SETTLE, ST_EXC, ST_LOW
  } pmdtc_state_e;
endpackage

// ### hw/pmdtc_clkdiv.sv
// Enable-pulse divider for the CPU state clock
`timescale 1ns/1ps
`default_nettype none
module pmdtc_clkdiv (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_en,
  input wire logic run,
  input wire logic [4:0] div,
  output logic tick
);
  import pmdtc_pkg::*;

  logic [4:0] cnt_ff;
  logic tick_ff;
  wire logic last = (cnt_ff >= div - 5'h01);
  wire logic [4:0] nxt_cnt = (!run) ? 5'h00 : (src_en ? (last ? 5'h00 : cnt_ff + 5'h01) : cnt_ff);
  wire logic nxt_tick = run && src_en && last;

  // Stopped clock restarts from a full period so the first state is never short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 5'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule // pmdtc_clkdiv
`default_nettype wire

// ### hw/pmdtc_top.sv
// Power-mode controller: medium-speed exit and direct transfers between run modes
// Overview of operation
// (R1) Medium-speed mode is left only by a sleep instruction or by reset.
// (R2) Medium speed, sleep with standby 1, low-speed 0, timer bit 0: standby.
// (R3) Medium speed, sleep with standby 1 and timer bit 1: watch mode.
// (R4) Medium speed, sleep with standby and low-speed both 0: sleep mode.
// (R5) Reset low puts the CPU into reset and ends medium-speed mode at once.
// (R6) Medium-speed CPU clock is one eighth of the high-speed clock.
// (R7) Tone generator keeps the undivided oscillator clock in medium speed.
// (R8) Direct-transfer enable makes sleep switch run modes, then raises the interrupt.
// (R9) Direct-transfer interrupt disabled: the attempt ends in sleep or watch.
// (R10) Interrupt mask set: sleep or watch is entered and no interrupt wakes it.
// (R11) High speed to medium speed via sleep when conditions of that transfer hold.
// (R12) Medium speed to high speed via sleep when conditions of that transfer hold.
// (R13) High or medium speed to subactive via watch when all four bits are 1.
// (R14) Subactive to high speed via watch, completing after the settling wait.
// (R15) Subactive to medium speed via watch, completing after the settling wait.
// (R16) Transfer time: 3 old-clock states plus 14 new-clock exception states.
// (R17) Out of subactive, settling wait is added, counted in new system clocks.
// (R18) Wait code 0..3 gives 8192 times 1,2,4,8 states; top bit gives 131072.
// (R19) Subactive CPU clock is watch clock divided by 2, 4 or 8.
// (R20) Mode is held in a register; control bits sampled only at sleep completion. Code reads wait bits after the old-clock states, divider bits live.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pmdtc_top #(
  parameter int SETTLE_BASE = pmdtc_pkg::SETTLE_BASE_STATES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_input_n,
  input wire logic sleep_req,
  input wire logic irq_mask,
  input wire logic wake_req,
  input wire logic watch_tick,
  output logic [2:0] mode,
  output logic cpu_clk_en,
  output logic tone_clk_en,
  output logic cpu_reset,
  output logic dt_irq,
  output logic xfer_busy
);
  import pmdtc_pkg::*;

  // ==========================================================
  // Settling wait decode
  function automatic logic [CNT_W-1:0] settle_states(input logic [2:0] code);
    logic [CNT_W-1:0] base;
    base = CNT_W'(SETTLE_BASE);
    if (code[2]) settle_states = base << WAIT_CODE_MAX; // R18
    else settle_states = base << code[1:0]; // R18
  endfunction

  // ==========================================================
  // Registers
  logic standby_select_ff, lspd_ff, mspd_ff, dten_ff, tmode_ff, dtien_ff;
  logic [2:0] wait_ff;
  logic [1:0] sadiv_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  pmdtc_mode_e mode_ff, ret_mode_ff, tgt_ff;
  pmdtc_state_e st_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic from_sub_ff, dt_irq_ff, busy_ff, cpurst_ff, tone_ff;

  // ==========================================================
  // APB decode; zero wait states, answer registered in the setup cycle
  wire logic setup = psel && !penable;
  wire logic wr_en = psel && penable && pready_ff && pwrite;
  wire logic hit_sc1 = (paddr == ADDR_SYSCTL1);
  wire logic hit_sc2 = (paddr == ADDR_SYSCTL2);
  wire logic hit_tmr = (paddr == ADDR_TMRMODE);
  wire logic hit_ien = (paddr == ADDR_IRQEN2);
  wire logic hit_st = (paddr == ADDR_STATUS);
  wire logic mapped = hit_sc1 || hit_sc2 || hit_tmr || hit_ien || hit_st;
  wire logic [31:0] sc1_val = {27'h0, wait_ff, lspd_ff, standby_select_ff};
  wire logic [31:0] sc2_val = {28'h0, sadiv_ff, dten_ff, mspd_ff};
  wire logic [31:0] st_val = {27'h0, cpurst_ff, busy_ff, 3'(mode_ff)};
  wire logic [31:0] rd_mux = hit_sc1 ? sc1_val :
                             hit_sc2 ? sc2_val :
                             hit_tmr ? {31'h0, tmode_ff} :
                             hit_ien ? {31'h0, dtien_ff} :
                             hit_st ? st_val : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped;
      prdata_ff <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {standby_select_ff, lspd_ff, mspd_ff, dten_ff, tmode_ff, dtien_ff} <= 6'h00;
      wait_ff <= 3'h0;
      sadiv_ff <= 2'h0;
    end else if (wr_en) begin
      if (hit_sc1) begin
        standby_select_ff <= pwdata[SC1_STANDBY_SELECT_BIT];
        lspd_ff <= pwdata[SC1_LSPD_BIT];
        wait_ff <= pwdata[SC1_WAIT_LSB +: 3];
      end
      if (hit_sc2) begin
        mspd_ff <= pwdata[SC2_MSPD_BIT];
        dten_ff <= pwdata[SC2_DTEN_BIT];
        sadiv_ff <= {pwdata[SC2_SADIV_HI_BIT], pwdata[SC2_SADIV_LO_BIT]};
      end
      if (hit_tmr) tmode_ff <= pwdata[TMR_MODE_BIT];
      if (hit_ien) dtien_ff <= pwdata[IEN_DT_BIT];
    end
  end

  // ==========================================================
  // CPU state clock
  wire logic in_high = (mode_ff == MD_HIGH);
  wire logic in_med = (mode_ff == MD_MED);
  wire logic in_sub = (mode_ff == MD_SUB);
  wire logic running = (in_high || in_med || in_sub) && reset_input_n;
  wire logic [4:0] sub_div = (sadiv_ff == 2'h0) ? DIV_SUB8 :
                             (sadiv_ff == 2'h1) ? DIV_SUB4 : DIV_SUB2; // R19
  wire logic [4:0] cur_div = in_sub ? sub_div : (in_med ? DIV_MED : DIV_HIGH); // R6
  wire logic div_src = in_sub ? watch_tick : 1'b1; // R19
  logic tick;

  pmdtc_clkdiv u_div (
    .pclk(pclk),
    .presetn(presetn),
    .src_en(div_src),
    .run(running),
    .div(cur_div),
    .tick(tick)
  );

  // ==========================================================
  // Sleep decode, sampled only when the instruction completes
  wire logic active = in_high || in_med;
  wire logic dt_ok = dten_ff && dtien_ff && !irq_mask; // R8 R9 R10
  wire logic to_med = active && in_high && !standby_select_ff && !lspd_ff && mspd_ff; // R11
  wire logic to_high = in_med && !standby_select_ff && !lspd_ff && !mspd_ff; // R12
  wire logic to_sub = active && standby_select_ff && lspd_ff && tmode_ff; // R13
  wire logic sub_out = in_sub && standby_select_ff && !lspd_ff && tmode_ff; // R14 R15
  wire logic dt_go = dt_ok && (to_med || to_high || to_sub || sub_out);
  wire pmdtc_mode_e dt_tgt = to_med ? MD_MED :
                             to_high ? MD_HIGH :
                             to_sub ? MD_SUB :
                             (mspd_ff ? MD_MED : MD_HIGH); // R14 R15
  wire pmdtc_mode_e low_tgt =
    (standby_select_ff && tmode_ff) ? MD_WATCH : // R3
    (active && standby_select_ff && !lspd_ff) ? MD_STANDBY : // R2
    (active && !standby_select_ff && !lspd_ff) ? MD_SLEEP : // R4
    (in_sub && !standby_select_ff && lspd_ff && tmode_ff) ? MD_SUBSLEEP : mode_ff;
  wire logic take = (st_ff == ST_RUN) && running && sleep_req; // R1 R20
  wire logic cnt_done = tick && (cnt_ff == '0);
  wire logic [CNT_W-1:0] pre_cnt = CNT_W'(PRE_STATES - 1);
  wire logic [CNT_W-1:0] exc_cnt = CNT_W'(EXC_STATES - 1);
  wire logic [CNT_W-1:0] set_cnt = settle_states(wait_ff) - CNT_W'(1);
  wire logic wake_ok = wake_req && !irq_mask; // R10

  // ==========================================================
  // Mode and transfer sequencer
  pmdtc_state_e nxt_st;
  pmdtc_mode_e nxt_mode, nxt_ret;
  logic [CNT_W-1:0] nxt_cnt;
  logic nxt_irq;

  always_comb begin
    nxt_st = st_ff;
    nxt_mode = mode_ff;
    nxt_ret = ret_mode_ff;
    nxt_cnt = (tick && cnt_ff != '0) ? cnt_ff - CNT_W'(1) : cnt_ff;
    nxt_irq = 1'b0;
    case (st_ff)
      ST_RUN: begin
        if (take && dt_go) begin
          nxt_st = ST_PRE; // R8
          nxt_cnt = pre_cnt; // R16
        end else if (take && low_tgt != mode_ff) begin
          nxt_st = ST_LOW; // R9
          nxt_ret = mode_ff;
          nxt_mode = low_tgt;
        end
      end
      ST_PRE: begin
        if (cnt_done) begin
          nxt_mode = tgt_ff;
          nxt_st = from_sub_ff ? ST_SETTLE : ST_EXC; // R17
          nxt_cnt = from_sub_ff ? set_cnt : exc_cnt; // R14 R15 R17
          nxt_irq = !from_sub_ff; // R8
        end
      end
      ST_SETTLE: begin
        if (cnt_done) begin
          nxt_st = ST_EXC;
          nxt_cnt = exc_cnt; // R17
          nxt_irq = 1'b1; // R8
        end
      end
      ST_EXC: begin
        if (cnt_done) nxt_st = ST_RUN; // R16
      end
      ST_LOW: begin
        if (wake_ok) begin
          nxt_st = ST_RUN;
          nxt_mode = ret_mode_ff;
        end
      end
      default: nxt_st = ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RUN;
      mode_ff <= MD_HIGH;
      ret_mode_ff <= MD_HIGH;
      tgt_ff <= MD_HIGH;
      cnt_ff <= '0;
      from_sub_ff <= 1'b0;
      dt_irq_ff <= 1'b0;
      busy_ff <= 1'b0;
      cpurst_ff <= 1'b1;
      tone_ff <= 1'b0;
    end else if (!reset_input_n) begin
      // Pin reset aborts any transfer and drops back to high speed at once
      st_ff <= ST_RUN; // R5 R1
      mode_ff <= MD_HIGH; // R5
      cnt_ff <= '0;
      dt_irq_ff <= 1'b0;
      busy_ff <= 1'b0;
      cpurst_ff <= 1'b1; // R5
      tone_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      mode_ff <= nxt_mode;
      ret_mode_ff <= nxt_ret;
      cnt_ff <= nxt_cnt;
      if (take) begin
        tgt_ff <= dt_tgt;
        from_sub_ff <= in_sub;
      end
      dt_irq_ff <= nxt_irq;
      busy_ff <= (nxt_st == ST_PRE) || (nxt_st == ST_SETTLE) || (nxt_st == ST_EXC);
      cpurst_ff <= 1'b0;
      // Oscillator runs unless standby, watch or subsleep stop it; never follows CPU divider
      tone_ff <= (nxt_mode != MD_STANDBY) && (nxt_mode != MD_WATCH) &&
                 (nxt_mode != MD_SUBSLEEP); // R7
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign mode = 3'(mode_ff);
  assign cpu_clk_en = tick;
  assign tone_clk_en = tone_ff;
  assign cpu_reset = cpurst_ff;
  assign dt_irq = dt_irq_ff;
  assign xfer_busy = busy_ff;
endmodule // pmdtc_top
`default_nettype wire

// ### bench/pmdtc_properties.sv
// Port timing checker of the power-mode controller
`timescale 1ns/1ps
`default_nettype none
module pmdtc_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic reset_input_n,
  input wire logic sleep_req,
  input wire logic [2:0] mode,
  input wire logic cpu_clk_en,
  input wire logic tone_clk_en,
  input wire logic cpu_reset,
  input wire logic dt_irq,
  input wire logic xfer_busy
);
  import pmdtc_pkg::*;
  // ==========================================================
  // Helpers: gap between CPU states, states since the interrupt
  logic [4:0] gap_ff;
  logic [4:0] exc_ff;
  logic [2:0] pmode_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_ff <= 5'h1f;
      exc_ff <= 5'h00;
      pmode_ff <= MD_SLEEP;
    end else begin
      gap_ff <= cpu_clk_en ? 5'h00 : (gap_ff == 5'h1f ? gap_ff : gap_ff + 5'h01);
      exc_ff <= dt_irq ? 5'h00 : exc_ff + 5'(cpu_clk_en);
      // Any mode change spoils the next gap, so it is not judged
      pmode_ff <= (!reset_input_n) ? MD_SLEEP :
                  (cpu_clk_en ? mode : (mode == pmode_ff ? pmode_ff : MD_SLEEP));
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Assertions
  a_reset_pin_cpu: assert property (!reset_input_n |=>
    mode == MD_HIGH && cpu_reset && !xfer_busy) else $error("reset pin ignored");
  a_med_hold_mode: assert property (
    (mode == MD_MED && !sleep_req && !xfer_busy && reset_input_n) |=> mode == MD_MED)
    else $error("medium speed left without cause");
  a_med_state_gap: assert property (
    (cpu_clk_en && !cpu_reset && mode == MD_MED && pmode_ff == MD_MED) |-> gap_ff == 5'd15)
    else $error("medium speed state rate wrong");
  a_high_state_gap: assert property (
    (cpu_clk_en && !cpu_reset && mode == MD_HIGH && pmode_ff == MD_HIGH) |-> gap_ff == 5'd1)
    else $error("high speed state rate wrong");
  a_tone_full_rate: assert property (mode == MD_MED |-> tone_clk_en)
    else $error("tone clock divided");
  a_busy_from_sleep: assert property ($rose(xfer_busy) |-> $past(sleep_req))
    else $error("transfer without sleep");
  a_irq_one_cycle: assert property (dt_irq |-> xfer_busy ##1 !dt_irq)
    else $error("transfer interrupt malformed");
  a_exc_fourteen: assert property (
    ($fell(xfer_busy) && $past(reset_input_n)) |-> (exc_ff + 5'(cpu_clk_en)) == 5'd14)
    else $error("exception state count wrong");
  a_apb_no_wait: assert property ((psel && !penable) |=> pready)
    else $error("access phase waited");
  c_irq: cover property (dt_irq);
  c_sub: cover property (mode == MD_SUB);
  c_done: cover property ($fell(xfer_busy));
endmodule // pmdtc_properties
bind pmdtc_top pmdtc_properties u_pmdtc_properties (.pclk, .presetn, .psel, .penable,
  .pready, .reset_input_n, .sleep_req, .mode, .cpu_clk_en, .tone_clk_en, .cpu_reset,
  .dt_irq, .xfer_busy);
`default_nettype wire

// ### bench/pmdtc_cpu_model.sv
// CPU core model: sleep instruction pulses and a free-running watch clock
`timescale 1ns/1ps
`default_nettype none
module pmdtc_cpu_model #(
  parameter int WATCH_DIV = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic xfer_busy,
  input wire logic cpu_clk_en,
  output logic sleep_req,
  output logic watch_tick
);
  int wcnt;
  initial sleep_req = 1'b0;
  // The watch clock never stops, so ticks run between transfers too
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt <= 0;
      watch_tick <= 1'b0;
    end else begin
      wcnt <= (wcnt == WATCH_DIV - 1) ? 0 : wcnt + 1;
      watch_tick <= (wcnt == 0);
    end
  end
  // A sleep completes just after a CPU state boundary, never during a transfer
  task automatic exec_sleep();
    @(posedge pclk iff (cpu_clk_en === 1'b1 && xfer_busy === 1'b0));
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
  endtask
endmodule // pmdtc_cpu_model
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench of the power-mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pmdtc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic reset_input_n, sleep_req, irq_mask, wake_req, watch_tick;
  logic [2:0] mode;
  logic cpu_clk_en, tone_clk_en, cpu_reset, dt_irq, xfer_busy;
  int fail_count = 0;
  int checked = 0;
  pmdtc_top #(.SETTLE_BASE(4)) u_pmdtc_top (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_input_n, .sleep_req, .irq_mask,
    .wake_req, .watch_tick, .mode, .cpu_clk_en, .tone_clk_en, .cpu_reset, .dt_irq,
    .xfer_busy);
  pmdtc_cpu_model u_cpu_model (.pclk, .presetn, .xfer_busy, .cpu_clk_en, .sleep_req,
    .watch_tick);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ==========================================================
  // Shared tasks
  task automatic wrap_up();
    $display("fail_count=%0d checked=%0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff (pready === 1'b1));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cfg(input logic [31:0] s1, s2, tm, ie);
    apb(1'b1, ADDR_SYSCTL1, s1);
    apb(1'b1, ADDR_SYSCTL2, s2);
    apb(1'b1, ADDR_TMRMODE, tm);
    apb(1'b1, ADDR_IRQEN2, ie);
  endtask
  // Sleep, then check the final mode and the cycles it took
  task automatic sleep_to(input logic [2:0] exp, input int lo, input int hi);
    longint t0;
    int n;
    u_cpu_model.exec_sleep();
    t0 = $time;
    repeat (2) @(posedge pclk);
    @(posedge pclk iff (xfer_busy === 1'b0));
    n = int'(($time - t0) / 8);
    @(negedge pclk);
    chk(32'(mode), 32'(exp));
    chk(32'(n >= lo && n <= hi), 32'h1);
    @(posedge pclk);
  endtask
  task automatic wake(input logic [2:0] exp);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    @(posedge pclk iff (mode < MD_SLEEP));
    @(negedge pclk);
    chk(32'(mode), 32'(exp));
    @(posedge pclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(err), 32'h1);
  endtask
  task automatic t_med_exits();
    logic [31:0] s1 [3] = '{32'h0, 32'h1, 32'h1};
    logic [31:0] tm [3] = '{32'h0, 32'h0, 32'h1};
    logic [2:0] ex [3] = '{MD_SLEEP, MD_STANDBY, MD_WATCH};
    for (int i = 0; i < 3; i++) begin
      cfg(s1[i], 32'h1, tm[i], 32'h1);
      sleep_to(ex[i], 0, 9);
      chk(32'(tone_clk_en), 32'(ex[i] == MD_SLEEP));
      wake(MD_MED);
    end
    chk(32'(tone_clk_en), 32'h1);
  endtask
  task automatic t_blocked();
    cfg(32'h0, 32'h2, 32'h0, 32'h0);
    sleep_to(MD_SLEEP, 0, 9);
    wake(MD_MED);
    cfg(32'h0, 32'h2, 32'h0, 32'h1);
    irq_mask <= 1'b1;
    sleep_to(MD_SLEEP, 0, 9);
    wake_req <= 1'b1;
    repeat (40) @(posedge pclk);
    @(negedge pclk);
    chk(32'(mode), 32'(MD_SLEEP));
    @(posedge pclk);
    wake_req <= 1'b0;
    irq_mask <= 1'b0;
    @(posedge pclk);
    wake(MD_MED);
  endtask
  task automatic t_direct();
    cfg(32'h3, 32'h2, 32'h1, 32'h1);
    sleep_to(MD_SUB, 0, 2000);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'(MD_SUB));
    cfg(32'h1, 32'h3, 32'h1, 32'h1);
    sleep_to(MD_MED, 360, 420);
    cfg(32'h0, 32'h2, 32'h0, 32'h1);
    sleep_to(MD_HIGH, 66, 86);
    cfg(32'h3, 32'h2, 32'h1, 32'h1);
    sleep_to(MD_SUB, 0, 2000);
    cfg(32'h11, 32'h2, 32'h1, 32'h1);
    apb(1'b0, ADDR_SYSCTL1, 32'h0);
    chk(rd, 32'h11);
    sleep_to(MD_HIGH, 230, 290);
  endtask
  task automatic t_reset_pin();
    cfg(32'h0, 32'h3, 32'h0, 32'h1);
    sleep_to(MD_MED, 220, 240);
    reset_input_n <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    chk(32'({mode, cpu_reset}), 32'({MD_HIGH, 1'b1}));
    @(posedge pclk);
    reset_input_n <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk(32'({mode, cpu_reset}), 32'({MD_HIGH, 1'b0}));
    @(posedge pclk);
    sleep_to(MD_MED, 220, 240);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, irq_mask, wake_req} = 6'h00;
    {paddr, pwdata, reset_input_n} = 41'h1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    cfg(32'h0, 32'h3, 32'h0, 32'h1);
    sleep_to(MD_MED, 220, 240);
    t_med_exits();
    t_blocked();
    t_direct();
    t_reset_pin();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
